// *** logic/sfc_defs.svh ***
// constants of the serial flash command and mode control block
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
// opcodes
`define SFC_OP_QUAD_ENTER   8'h38
`define SFC_OP_QUAD_EXIT    8'hFF
`define SFC_OP_RESET_ARM    8'h66
`define SFC_OP_RESET_FIRE   8'h99
`define SFC_OP_WRITE_ARM    8'h06
`define SFC_OP_WRITE_DISARM 8'h04
`define SFC_OP_STATUS_READ  8'h05
`define SFC_OP_STATUS_WRITE 8'h01
`define SFC_OP_PAGE_PROGRAM 8'h02
`define SFC_OP_SECTOR_ERASE 8'h20
`define SFC_OP_BLOCK_ERASE  8'hD8
`define SFC_OP_CHIP_ERASE_A 8'hC7
`define SFC_OP_CHIP_ERASE_B 8'h60
`define SFC_OP_POWER_DOWN   8'hB9
`define SFC_OP_RELEASE_ID   8'hAB
`define SFC_OP_MAKER_ID     8'h90
`define SFC_OP_JEDEC_ID     8'h9F
`define SFC_OP_OTP_ENTER    8'h3A
`define SFC_OP_READ         8'h03
`define SFC_OP_FAST_READ    8'h0B
`define SFC_OP_DUAL_OUT     8'h3B
`define SFC_OP_DUAL_IO      8'hBB
`define SFC_OP_QUAD_IO      8'hEB
// status byte field positions
`define SFC_ST_BUSY         0
`define SFC_ST_WLF          1
// reset recovery after an aborted erase
`define SFC_CLOCK_NS        40
`define SFC_RECOVER_NS      28000
`define SFC_RECOVER_CYCLES  ((`SFC_RECOVER_NS + `SFC_CLOCK_NS - 1) / `SFC_CLOCK_NS)
`endif

// *** logic/sfc_pkg.sv ***
// types of the serial flash command and mode control block
package sfc_pkg;
   typedef enum logic [1:0] {PH_OP, PH_ADR, PH_DAT, PH_IGN} sfc_phase_type;

   // command handed to the program/erase engine at frame end
   typedef struct packed {
      logic        valid;
      logic [7:0]  code;
      logic [23:0] addr;
   } sfc_cmd_type;

   // state of the logic on the serial clock
   typedef struct packed {
      sfc_phase_type phase;
      logic [7:0]    op;
      logic [3:0]    opn;
      logic          op_done;
      logic [2:0]    cnt3;
      logic [23:0]   sh;
      logic [5:0]    need;
      logic [23:0]   addr;
      logic          b4;
      logic [7:0]    obyte;
      logic [2:0]    opos;
      logic [1:0]    idx;
      logic          tog;
      logic [7:0]    st1;
      logic [7:0]    st2;
   } sfc_link_type;

   // lane drivers, updated on the falling serial clock edge
   typedef struct packed {
      logic [3:0] val;
      logic [3:0] oe;
   } sfc_pin_type;

   // state of the logic on the system clock
   typedef struct packed {
      logic        cs1;
      logic        cs2;
      logic        cs3;
      logic        tog1;
      logic        tog2;
      logic        seen;
      logic        quad;
      logic        wlf;
      logic        arm;
      logic        otp;
      logic        pd;
      logic [9:0]  rec;
      logic        recovering;
      logic        soft_reset;
      logic [7:0]  status;
      sfc_cmd_type cmd;
   } sfc_sys_type;
endpackage

// *** logic/sfc_control.sv ***
// serial flash command decoding and lane mode control
`timescale 1ns/1ps
`include "sfc_defs.svh"

module sfc_control #(
   parameter logic [7:0] MAKER_CODE  = 8'hA5, // arbitrary value
   parameter logic [7:0] TYPE_CODE   = 8'h5A, // arbitrary value
   parameter logic [7:0] CAP_CODE    = 8'h3C, // arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'hC3  // arbitrary value
) (
   input  wire logic                 i_clock,
   input  wire logic                 i_resetn,
   input  wire logic                 i_link_clock,
   input  wire logic                 i_cs_n,
   input  wire logic [3:0]           i_lane,
   output logic      [3:0]           o_lane,
   output logic      [3:0]           o_lane_oe,
   output logic      [23:0]          o_mem_addr,
   input  wire logic [7:0]           i_mem_data,
   input  wire logic                 i_busy,
   input  wire logic                 i_write_done,
   input  wire logic [5:0]           i_status_upper,
   output logic                      o_quad_mode,
   output logic                      o_write_latch,
   output logic                      o_otp_mode,
   output logic                      o_deep_power_down,
   output logic                      o_soft_reset,
   output logic                      o_recovering,
   output sfc_pkg::sfc_cmd_type      o_cmd
);

   localparam logic [9:0] RECOVER_CYCLES = 10'(`SFC_RECOVER_CYCLES);

   sfc_pkg::sfc_link_type lq;
   sfc_pkg::sfc_link_type ld;
   sfc_pkg::sfc_pin_type  pq;
   sfc_pkg::sfc_pin_type  pd;
   sfc_pkg::sfc_sys_type  sq;
   sfc_pkg::sfc_sys_type  sd;
   logic                  live_q;
   logic                  link_kill;

   // lanes taken per clock while the host is sending
   function automatic logic [2:0] in_width(input logic [7:0] op,
                                           input sfc_pkg::sfc_phase_type ph,
                                           input logic quad);
      if (quad)
         in_width = 3'h4;
      else if (ph == sfc_pkg::PH_ADR && op == `SFC_OP_DUAL_IO)
         in_width = 3'h2;
      else if (ph == sfc_pkg::PH_ADR && op == `SFC_OP_QUAD_IO)
         in_width = 3'h4;
      else
         in_width = 3'h1;
   endfunction

   // lanes driven per clock while the device answers
   function automatic logic [2:0] out_width(input logic [7:0] op, input logic quad);
      if (quad || op == `SFC_OP_QUAD_IO)
         out_width = 3'h4;
      else if (op == `SFC_OP_DUAL_OUT || op == `SFC_OP_DUAL_IO)
         out_width = 3'h2;
      else
         out_width = 3'h1;
   endfunction

   // bits that follow the opcode before the answer or the end
   function automatic logic [5:0] need_bits(input logic [7:0] op);
      case (op)
         `SFC_OP_READ, `SFC_OP_PAGE_PROGRAM, `SFC_OP_SECTOR_ERASE,
         `SFC_OP_BLOCK_ERASE, `SFC_OP_MAKER_ID, `SFC_OP_RELEASE_ID:
            need_bits = 6'h18;
         `SFC_OP_FAST_READ, `SFC_OP_DUAL_OUT, `SFC_OP_DUAL_IO:
            need_bits = 6'h20;
         `SFC_OP_QUAD_IO:
            need_bits = 6'h30;
         `SFC_OP_STATUS_WRITE:
            need_bits = 6'h08;
         default:
            need_bits = 6'h00;
      endcase
   endfunction

   // dummy bits that trail the address
   function automatic logic [5:0] dummy_bits(input logic [7:0] op);
      case (op)
         `SFC_OP_FAST_READ, `SFC_OP_DUAL_OUT, `SFC_OP_DUAL_IO: dummy_bits = 6'h08;
         `SFC_OP_QUAD_IO:                                      dummy_bits = 6'h18;
         default:                                              dummy_bits = 6'h00;
      endcase
   endfunction

   function automatic logic is_read(input logic [7:0] op);
      is_read = (op == `SFC_OP_READ) || (op == `SFC_OP_FAST_READ) ||
                (op == `SFC_OP_DUAL_OUT) || (op == `SFC_OP_DUAL_IO) ||
                (op == `SFC_OP_QUAD_IO);
   endfunction

   // byte number idx of an identification or status answer
   function automatic logic [7:0] id_byte(input logic [7:0] op, input logic [1:0] idx,
                                          input logic b4, input logic [7:0] st);
      case (op)
         `SFC_OP_STATUS_READ: id_byte = st;
         `SFC_OP_RELEASE_ID:  id_byte = DEVICE_CODE;
         `SFC_OP_MAKER_ID:    id_byte = (idx[0] ^ b4) ? DEVICE_CODE : MAKER_CODE;
         `SFC_OP_JEDEC_ID: begin
            case (idx)
               2'h0:    id_byte = MAKER_CODE;
               2'h1:    id_byte = TYPE_CODE;
               2'h2:    id_byte = CAP_CODE;
               default: id_byte = 8'h00;
            endcase
         end
         default:             id_byte = 8'h00;
      endcase
   endfunction

   // lanes are killed the moment the chip select rises or reset falls
   assign link_kill = i_cs_n | ~i_resetn;

   // marks the frame as running from its first rising edge
   always_ff @(posedge i_link_clock or posedge link_kill) begin
      if (link_kill)
         live_q <= 1'b0;
      else
         live_q <= 1'b1;
   end

   // serial side: shifting, decoding and answer sequencing
   always_comb begin
      logic [2:0]  w;
      logic [2:0]  wo;
      logic [23:0] ins;
      logic [7:0]  nop;
      logic [3:0]  opos_n;
      w      = 3'h1;
      wo     = 3'h1;
      ins    = 24'h000000;
      nop    = 8'h00;
      opos_n = 4'h0;
      ld     = lq;
      // a fresh frame restarts decoding but keeps the last record until now
      if (!live_q) begin
         ld.phase   = sfc_pkg::PH_OP;
         ld.op      = 8'h00;
         ld.opn     = 4'h0;
         ld.op_done = 1'b0;
         ld.cnt3    = 3'h0;
         ld.sh      = 24'h000000;
         ld.need    = 6'h00;
         ld.b4      = 1'b0;
         ld.idx     = 2'h0;
         ld.opos    = 3'h0;
         ld.tog     = ~lq.tog;
      end
      // status byte crosses on two flops, fresh each clock of the frame
      ld.st1 = sq.status;
      ld.st2 = lq.st1;
      w  = in_width(ld.op, ld.phase, sq.quad);
      wo = out_width(ld.op, sq.quad);
      case (w)
         3'h2:    ins = {ld.sh[21:0], i_lane[1], i_lane[0]};
         3'h4:    ins = {ld.sh[19:0], i_lane};
         default: ins = {ld.sh[22:0], i_lane[0]};
      endcase
      ld.cnt3 = ld.cnt3 + w;
      case (ld.phase)
         sfc_pkg::PH_OP: begin
            nop    = (w == 3'h4) ? {ld.op[3:0], i_lane} : {ld.op[6:0], i_lane[0]};
            ld.op  = nop;
            ld.opn = ld.opn + 4'(w);
            if (ld.opn == 4'h8) begin
               ld.op_done = 1'b1;
               if ((sq.pd && nop != `SFC_OP_RELEASE_ID) ||
                   (sq.quad && (nop == `SFC_OP_READ || nop == `SFC_OP_DUAL_OUT ||
                                nop == `SFC_OP_DUAL_IO)))
                  ld.phase = sfc_pkg::PH_IGN;
               else if (need_bits(nop) != 6'h00) begin
                  ld.phase = sfc_pkg::PH_ADR;
                  ld.need  = need_bits(nop);
               end else if (nop == `SFC_OP_STATUS_READ || nop == `SFC_OP_JEDEC_ID) begin
                  ld.phase = sfc_pkg::PH_DAT;
                  ld.obyte = id_byte(nop, 2'h0, 1'b0, lq.st2);
               end else
                  ld.phase = sfc_pkg::PH_IGN;
            end
         end
         sfc_pkg::PH_ADR: begin
            ld.sh   = ins;
            ld.need = ld.need - 6'(w);
            if (ld.need == dummy_bits(ld.op))
               ld.addr = ins;
            if (ld.need == 6'h00) begin
               if (ld.op == `SFC_OP_MAKER_ID)
                  ld.b4 = ins[0];
               if (is_read(ld.op) || ld.op == `SFC_OP_MAKER_ID ||
                   ld.op == `SFC_OP_RELEASE_ID) begin
                  ld.phase = sfc_pkg::PH_DAT;
                  ld.obyte = id_byte(ld.op, 2'h0, ld.b4, lq.st2);
               end else
                  ld.phase = sfc_pkg::PH_IGN;
            end
         end
         sfc_pkg::PH_DAT: begin
            // the host took the chunk on this edge; step to the next one
            opos_n  = {1'b0, ld.opos} + {1'b0, wo};
            ld.opos = opos_n[2:0];
            if (opos_n == 4'h8) begin
               // the jedec answer stops on its zero byte, the maker pairs wrap
               ld.idx   = (ld.idx == 2'h3 && ld.op == `SFC_OP_JEDEC_ID) ? 2'h3 : ld.idx + 2'h1;
               ld.addr  = ld.addr + 24'h000001;
               ld.obyte = id_byte(ld.op, ld.idx, ld.b4, lq.st2);
            end
         end
         default: begin
            // ignored frames only count clocks for the alignment check
         end
      endcase
   end

   always_ff @(posedge i_link_clock or negedge i_resetn) begin
      if (!i_resetn)
         lq <= '0;
      else
         lq <= ld;
   end

   // answer chunk for the falling edge; reads take the array byte live
   always_comb begin
      logic [7:0] src;
      logic [7:0] shv;
      logic [2:0] wo;
      src = is_read(lq.op) ? i_mem_data : lq.obyte;
      shv = src << lq.opos;
      wo  = out_width(lq.op, sq.quad);
      pd  = '0;
      if (live_q && lq.phase == sfc_pkg::PH_DAT) begin
         case (wo)
            3'h2: begin
               pd.val = {2'b00, shv[7], shv[6]};
               pd.oe  = 4'h3;
            end
            3'h4: begin
               pd.val = shv[7:4];
               pd.oe  = 4'hF;
            end
            default: begin
               pd.val = {2'b00, shv[7], 1'b0};
               pd.oe  = 4'h2;
            end
         endcase
      end
   end

   // lanes change on the falling edge so the host samples on the rising one
   always_ff @(negedge i_link_clock or posedge link_kill) begin
      if (link_kill)
         pq <= '0;
      else
         pq <= pd;
   end

   // system side: frame end commit, mode flags and reset sequencing
   always_comb begin
      logic commit;
      logic aligned;
      logic [7:0] op;
      sd      = sq;
      commit  = 1'b0;
      aligned = 1'b0;
      op      = lq.op;
      sd.cs1  = i_cs_n;
      sd.cs2  = sq.cs1;
      sd.cs3  = sq.cs2;
      sd.tog1 = lq.tog;
      sd.tog2 = sq.tog1;
      sd.soft_reset = 1'b0;
      sd.cmd.valid  = 1'b0;
      if (sq.rec != 10'h000)
         sd.rec = sq.rec - 10'h001;
      if (i_write_done)
         sd.wlf = 1'b0;
      // link record is frozen while chip select stays high
      if (sq.cs2 && !sq.cs3 && sq.tog2 != sq.seen) begin
         sd.seen = sq.tog2;
         commit  = lq.op_done;
      end
      aligned = (lq.cnt3 == 3'h0);
      if (commit && !(sq.pd && op != `SFC_OP_RELEASE_ID)) begin
         sd.arm = 1'b0;
         case (op)
            `SFC_OP_RELEASE_ID:
               sd.pd = 1'b0;
            `SFC_OP_RESET_ARM:
               sd.arm = aligned;
            `SFC_OP_RESET_FIRE: begin
               if (aligned && sq.arm) begin
                  sd.quad       = 1'b0;
                  sd.wlf        = 1'b0;
                  sd.otp        = 1'b0;
                  sd.soft_reset = 1'b1;
                  if (i_busy)
                     sd.rec = RECOVER_CYCLES;
               end
            end
            `SFC_OP_WRITE_ARM:
               if (aligned)
                  sd.wlf = 1'b1;
            `SFC_OP_WRITE_DISARM:
               if (aligned) begin
                  if (sq.otp)
                     sd.otp = 1'b0;
                  else
                     sd.wlf = 1'b0;
               end
            `SFC_OP_QUAD_ENTER:
               if (aligned)
                  sd.quad = 1'b1;
            `SFC_OP_QUAD_EXIT:
               if (aligned && sq.quad)
                  sd.quad = 1'b0;
            `SFC_OP_OTP_ENTER:
               if (aligned)
                  sd.otp = 1'b1;
            `SFC_OP_POWER_DOWN:
               if (aligned)
                  sd.pd = 1'b1;
            `SFC_OP_STATUS_WRITE, `SFC_OP_PAGE_PROGRAM, `SFC_OP_SECTOR_ERASE,
            `SFC_OP_BLOCK_ERASE, `SFC_OP_CHIP_ERASE_A, `SFC_OP_CHIP_ERASE_B: begin
               // the engine checks the latch and its own length limits
               sd.cmd.valid = aligned;
               sd.cmd.code  = op;
               sd.cmd.addr  = lq.addr;
            end
            default: begin
               // reads and unknown opcodes only cancel a pending arm
            end
         endcase
      end
      sd.recovering = (sd.rec != 10'h000);
      sd.status = {i_status_upper, sd.wlf, i_busy | sd.recovering};
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn)
         sq <= '{cs1: 1'b1, cs2: 1'b1, cs3: 1'b1, default: '0};
      else
         sq <= sd;
   end

   assign o_lane            = pq.val;
   assign o_lane_oe         = pq.oe;
   assign o_mem_addr        = lq.addr;
   assign o_quad_mode       = sq.quad;
   assign o_write_latch     = sq.wlf;
   assign o_otp_mode        = sq.otp;
   assign o_deep_power_down = sq.pd;
   assign o_soft_reset      = sq.soft_reset;
   assign o_recovering      = sq.recovering;
   assign o_cmd             = sq.cmd;

endmodule // sfc_control

// *** bench/sfc_host.sv ***
// host side model of the serial flash link: clock, chip select and lanes
`timescale 1ns/1ps
module sfc_host (
   output logic            o_link_clock,
   output logic            o_cs_n,
   output logic      [3:0] o_lane,
   input  wire logic [3:0] i_dev_lane,
   input  wire logic [3:0] i_dev_oe
);
   logic [3:0] hv;
   logic [3:0] hoe;

   // a lane nobody drives shows the inverse of its last value, so stale bits never match
   assign o_lane = (hoe & hv) | (~hoe & i_dev_oe & i_dev_lane) | (~hoe & ~i_dev_oe & ~hv);

   initial begin
      o_link_clock = 1'b0;
      o_cs_n = 1'b1;
      hv = 4'h0;
      hoe = 4'h0;
   end

   // one link clock: launch on the low phase, capture at the rising edge
   task automatic tick(input int w, input logic [3:0] d, input logic drv, inout logic [63:0] r);
      hoe = drv ? ((w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1) : 4'h0;
      if (drv) hv = d;
      #40 o_link_clock = 1'b1;
      r = (w == 4) ? {r[59:0], o_lane} : (w == 2) ? {r[61:0], o_lane[1:0]} : {r[62:0], o_lane[1]};
      #40 o_link_clock = 1'b0;
   endtask

   // one framed command: opcode, address or dummy bits, then read bits; clock idles low
   task automatic xfer(input int ow, input int ob, input logic [7:0] op, input int aw,
                       input int an, input logic [47:0] ab, input int rw, input int rn,
                       output logic [63:0] rx);
      logic [63:0] r;
      r = '0;
      o_cs_n = 1'b0;
      for (int i = ob - ow; i >= 0; i -= ow) tick(ow, 4'(op >> i), 1'b1, r);
      for (int i = an - aw; i >= 0; i -= aw) tick(aw, 4'(ab >> i), 1'b1, r);
      r = '0;
      for (int i = 0; i < rn; i += rw) tick(rw, 4'h0, 1'b0, r);
      #40 o_cs_n = 1'b1;
      hoe = 4'h0;
      rx = r;
      #400; // idle gap well above the three system cycles the device needs
   endtask
endmodule // sfc_host

// *** bench/sfc_control_properties.sv ***
// assertions on the ports of the serial flash command and mode control
`timescale 1ns/1ps
`include "sfc_defs.svh"
module sfc_control_properties (
   input wire logic                 i_clock,
   input wire logic                 i_resetn,
   input wire logic                 i_cs_n,
   input wire logic                 i_write_done,
   input wire logic [3:0]           o_lane_oe,
   input wire logic                 o_quad_mode,
   input wire logic                 o_write_latch,
   input wire logic                 o_deep_power_down,
   input wire logic                 o_soft_reset,
   input wire logic                 o_recovering,
   input wire sfc_pkg::sfc_cmd_type o_cmd
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   // consecutive cycles of the recovery wait
   logic [10:0] rec_len;
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn)
         rec_len <= 11'h000;
      else
         rec_len <= o_recovering ? rec_len + 11'h001 : 11'h000;
   end

   // lanes are released whenever the host deselects
   property p_oe_idle;
      i_cs_n |-> o_lane_oe == 4'h0;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("lanes driven while deselected");

   // only one, two or four lane drive patterns exist
   property p_oe_shape;
      !i_cs_n |-> o_lane_oe inside {4'h0, 4'h2, 4'h3, 4'hF};
   endproperty
   a_oe_shape: assert property (p_oe_shape) else $error("odd lane drive pattern");

   // mode changes only right after a frame has ended
   property p_quad_frame;
      $changed(o_quad_mode) |-> $past(i_cs_n, 2) && !$past(i_cs_n, 6);
   endproperty
   a_quad_frame: assert property (p_quad_frame) else $error("quad mode moved outside frame");

   property p_latch_set;
      $rose(o_write_latch) |-> $past(i_cs_n, 2) && !$past(i_cs_n, 6);
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch set outside frame");

   // latch drops after a frame or an engine completion
   property p_latch_clr;
      $fell(o_write_latch) |-> $past(i_write_done) || $past(i_write_done, 2)
         || ($past(i_cs_n, 2) && !$past(i_cs_n, 6));
   endproperty
   a_latch_clr: assert property (p_latch_clr) else $error("latch cleared without cause");

   property p_cmd_frame;
      o_cmd.valid |-> $past(i_cs_n, 2) && !$past(i_cs_n, 6) ##1 !o_cmd.valid;
   endproperty
   a_cmd_frame: assert property (p_cmd_frame) else $error("command handed over badly");

   // a reset pulse is single and leaves quad mode at once
   property p_reset_pulse;
      o_soft_reset |-> $past(i_cs_n, 2) && !o_quad_mode ##1 !o_soft_reset;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse malformed");

   property p_reset_dpd;
      o_soft_reset |-> !o_deep_power_down;
   endproperty
   a_reset_dpd: assert property (p_reset_dpd) else $error("reset fired in power down");

   // the recovery wait lasts about 28 us of system clocks
   property p_recover;
      $fell(o_recovering) |-> rec_len == 11'(`SFC_RECOVER_CYCLES);
   endproperty
   a_recover: assert property (p_recover) else $error("recovery length wrong");
endmodule // sfc_control_properties

bind sfc_control sfc_control_properties u_props (
   .i_clock(i_clock), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_write_done(i_write_done),
   .o_lane_oe(o_lane_oe), .o_quad_mode(o_quad_mode), .o_write_latch(o_write_latch),
   .o_deep_power_down(o_deep_power_down), .o_soft_reset(o_soft_reset),
   .o_recovering(o_recovering), .o_cmd(o_cmd)
);

// *** bench/sfc_control_tb_top.sv ***
// self-checking bench of the serial flash command and mode control
`timescale 1ns/1ps
module sfc_control_tb_top;
   localparam logic [7:0] MK = 8'h4E; // arbitrary value
   localparam logic [7:0] TY = 8'h71; // arbitrary value
   localparam logic [7:0] CP = 8'h2B; // arbitrary value
   localparam logic [7:0] DV = 8'hD6; // arbitrary value
   logic                 i_clock, i_resetn, i_busy, i_write_done, link_clock, cs_n;
   logic [5:0]           i_status_upper;
   logic [7:0]           i_mem_data;
   logic [3:0]           lane, o_lane, o_lane_oe, oe_seen;
   logic [23:0]          o_mem_addr, a;
   logic                 o_quad_mode, o_write_latch, o_otp_mode, o_deep_power_down;
   logic                 o_soft_reset, o_recovering;
   sfc_pkg::sfc_cmd_type o_cmd, cmd_seen;
   logic [63:0]          rx;
   int                   error_cnt = 0, checks = 0, sr_cnt = 0, s, n;
   logic [7:0]           refused [3] = '{8'h03, 8'h3B, 8'hBB};

   // array contents are a fixed scramble of the address
   function automatic logic [7:0] mem_f(input logic [23:0] ad);
      return ad[7:0] ^ ad[15:8] ^ ad[23:16] ^ 8'h96;
   endfunction
   function automatic logic [7:0] st_f(input logic wl);
      return {i_status_upper, wl, i_busy};
   endfunction
   assign i_mem_data = mem_f(o_mem_addr);

   sfc_control #(.MAKER_CODE(MK), .TYPE_CODE(TY), .CAP_CODE(CP), .DEVICE_CODE(DV)) dut (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_link_clock(link_clock), .i_cs_n(cs_n),
      .i_lane(lane), .o_lane(o_lane), .o_lane_oe(o_lane_oe), .o_mem_addr(o_mem_addr),
      .i_mem_data(i_mem_data), .i_busy(i_busy), .i_write_done(i_write_done),
      .i_status_upper(i_status_upper), .o_quad_mode(o_quad_mode),
      .o_write_latch(o_write_latch), .o_otp_mode(o_otp_mode),
      .o_deep_power_down(o_deep_power_down), .o_soft_reset(o_soft_reset),
      .o_recovering(o_recovering), .o_cmd(o_cmd));
   sfc_host u_host (.o_link_clock(link_clock), .o_cs_n(cs_n), .o_lane(lane),
                    .i_dev_lane(o_lane), .i_dev_oe(o_lane_oe));

   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   // lanes the device drove in a frame, and reset pulses seen
   always @(posedge link_clock) if (!cs_n) oe_seen |= o_lane_oe;
   always @(negedge i_clock) if (o_soft_reset === 1'b1) sr_cnt++;
   always @(negedge i_clock) if (o_cmd.valid === 1'b1) cmd_seen = o_cmd;

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one frame from the host, then settle on a falling system edge
   task automatic fr(input int w, input int b, input logic [7:0] c, input int aw, input int an,
                     input logic [47:0] ab, input int rw, input int rn);
      oe_seen = 4'h0;
      u_host.xfer(w, b, c, aw, an, ab, rw, rn, rx);
      @(negedge i_clock);
   endtask

   // a hang counts as a mismatch
   initial begin
      #3000000;
      error_cnt++;
      results();
   end

   initial begin
      i_resetn = 1'b0;
      i_busy = 1'b0;
      i_write_done = 1'b0;
      i_status_upper = 6'h00;
      void'($urandom(32'h047A7704));
      repeat (12) @(negedge i_clock);
      i_resetn = 1'b1;
      repeat (3) @(negedge i_clock);
      check("latch", o_write_latch, 1'b0);
      // latch set, otp leave before latch clear, a cut frame dropped, engine completion
      fr(1, 8, 8'h06, 1, 0, 0, 1, 0); check("latch", o_write_latch, 1'b1);
      fr(1, 8, 8'h3A, 1, 0, 0, 1, 0); fr(1, 8, 8'h04, 1, 0, 0, 1, 0);
      check("otp", o_otp_mode, 1'b0);
      check("latch", o_write_latch, 1'b1);
      for (n = 0; n < 4; n++) begin
         i_busy = 1'($urandom);
         i_status_upper = 6'($urandom);
         a = 24'($urandom);
         fr(1, 8, 8'h05, 1, 0, 0, 1, 16); check("status", rx[15:0], {2{st_f(1'b1)}});
         fr(1, 8, 8'h03, 1, 24, {24'h0, a}, 1, 8); check("read", rx[7:0], mem_f(a));
         fr(1, 8, 8'h3B, 1, 32, {16'h0, a, 8'h00}, 2, 16);
         check("dual out", rx[15:0], {mem_f(a), mem_f(a + 24'h1)});
         fr(1, 8, 8'hBB, 2, 32, {16'h0, a, 8'h00}, 2, 16);
         check("dual io", rx[15:0], {mem_f(a), mem_f(a + 24'h1)});
      end
      i_busy = 1'b0;
      fr(1, 8, 8'h04, 1, 0, 0, 1, 0); check("latch", o_write_latch, 1'b0);
      fr(1, 7, 8'h06, 1, 0, 0, 1, 0); check("latch", o_write_latch, 1'b0);
      fr(1, 8, 8'h06, 1, 0, 0, 1, 0);
      i_write_done = 1'b1;
      @(negedge i_clock);
      i_write_done = 1'b0;
      repeat (2) @(negedge i_clock);
      check("latch", o_write_latch, 1'b0);
      // erase command handed over only on a byte boundary
      a = 24'($urandom);
      cmd_seen = '0;
      fr(1, 8, 8'h20, 1, 23, {24'h0, a}, 1, 0); check("cut cmd", cmd_seen, 33'h0);
      fr(1, 8, 8'h20, 1, 24, {24'h0, a}, 1, 0); check("cmd", cmd_seen, {1'b1, 8'h20, a});
      // identification formats and an unknown opcode
      fr(1, 8, 8'hAB, 1, 24, 0, 1, 16); check("id", rx[15:0], {DV, DV});
      fr(1, 8, 8'h90, 1, 24, 0, 1, 48); check("maker", rx[47:0], {3{MK, DV}});
      fr(1, 8, 8'h90, 1, 24, 1, 1, 48); check("device", rx[47:0], {3{DV, MK}});
      fr(1, 8, 8'h9F, 1, 0, 0, 1, 24); check("jedec", rx[23:0], {MK, TY, CP});
      fr(1, 8, 8'hE7, 1, 0, 0, 1, 8); check("unknown", oe_seen, 4'h0);
      // full quad mode
      fr(1, 8, 8'h38, 1, 0, 0, 1, 0); check("quad", o_quad_mode, 1'b1);
      fr(4, 8, 8'h05, 4, 0, 0, 4, 16); check("q status", rx[15:0], {2{st_f(1'b0)}});
      a = 24'($urandom);
      fr(4, 8, 8'hEB, 4, 48, {a, 24'h0}, 4, 16);
      check("quad io", rx[15:0], {mem_f(a), mem_f(a + 24'h1)});
      foreach (refused[k]) begin
         fr(4, 8, refused[k], 4, 24, 0, 4, 8); check("refused", oe_seen, 4'h0);
      end
      fr(4, 8, 8'h06, 4, 0, 0, 4, 0); check("q latch", o_write_latch, 1'b1);
      fr(4, 8, 8'hFF, 4, 0, 0, 4, 0); check("quad", o_quad_mode, 1'b0);
      fr(1, 8, 8'hFF, 1, 0, 0, 1, 0); check("quad", o_quad_mode, 1'b0);
      // reset pairs: cancelled, good, quad format, back in standard, power down
      s = sr_cnt;
      fr(1, 8, 8'h66, 1, 0, 0, 1, 0); fr(1, 8, 8'h04, 1, 0, 0, 1, 0);
      fr(1, 8, 8'h99, 1, 0, 0, 1, 0); check("cancel", 64'(sr_cnt), 64'(s));
      fr(1, 8, 8'h06, 1, 0, 0, 1, 0);
      fr(1, 8, 8'h66, 1, 0, 0, 1, 0); fr(1, 8, 8'h99, 1, 0, 0, 1, 0);
      check("reset", 64'(sr_cnt), 64'(s + 1));
      check("reset latch", o_write_latch, 1'b0);
      fr(1, 8, 8'h38, 1, 0, 0, 1, 0); fr(4, 8, 8'h66, 4, 0, 0, 4, 0);
      fr(4, 8, 8'h99, 4, 0, 0, 4, 0); check("q reset", 64'(sr_cnt), 64'(s + 2));
      check("quad", o_quad_mode, 1'b0);
      fr(1, 8, 8'h66, 1, 0, 0, 1, 0); fr(1, 8, 8'h99, 1, 0, 0, 1, 0);
      check("std reset", 64'(sr_cnt), 64'(s + 3));
      fr(1, 8, 8'hB9, 1, 0, 0, 1, 0); fr(1, 8, 8'h66, 1, 0, 0, 1, 0);
      fr(1, 8, 8'h99, 1, 0, 0, 1, 0); check("pd", o_deep_power_down, 1'b1);
      check("pd reset", 64'(sr_cnt), 64'(s + 3));
      fr(1, 8, 8'hAB, 1, 24, 0, 1, 8); check("pd", o_deep_power_down, 1'b0);
      i_busy = 1'b1;
      fr(1, 8, 8'h66, 1, 0, 0, 1, 0); fr(1, 8, 8'h99, 1, 0, 0, 1, 0);
      i_busy = 1'b0;
      check("recovering", o_recovering, 1'b1);
      n = 0;
      while (o_recovering === 1'b1 && n < 1000) begin
         @(negedge i_clock);
         n++;
      end
      check("recover end", o_recovering, 1'b0);
      check("recover long", 64'(n > 600), 64'(1));
      results();
   end
endmodule // sfc_control_tb_top
